/* File: hdl/tpf_pin_sync.sv */
/*
 * Synchroniser and edge detector for the external count pin.
 * Assumes the pin is asynchronous to clk and each level lasts more
 * than one clk cycle.
 */
`include "tpf_cfg.svh"

module tpf_pin_sync
	import tpf_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,
	input  wire logic rising_sel,
	output logic      edge_pulse
);

	tpf_sync_st_t st;
	tpf_sync_st_t next_st;

	// ------------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree.
	// ------------------------------------------------------------------
	always_comb begin
		next_st         = st;
		next_st.stop    = 1'b0;
		next_st.q1      = pin;
		next_st.q2      = st.q1;
		next_st.q3      = st.q2;
		if (st.q2 == st.q3) begin
			next_st.pin_lvl = st.q3;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// One pulse per selected edge of the filtered level.
	assign edge_pulse = rising_sel ? (st.q3 & ~st.pin_lvl & (st.q2 == st.q3))
	                               : (~st.q3 & st.pin_lvl & (st.q2 == st.q3));

endmodule // tpf_pin_sync

/* File: hdl/tpf_top.sv */
/*
 * Timer clock source and event flag block: free running prescaler, external
 * pin count, prescaler reset control, overflow and compare flags, requests.
 * Assumes an APB master, a counter core that returns its count and step
 * strobes, and a core that acknowledges vectors with one-cycle strobes.
 */
`include "tpf_cfg.svh"

module tpf_top
	import tpf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        external_count_pin,
	input  wire logic        global_irq_enable,
	input  wire tpf_ack_t    vec_ack,
	input  wire tpf_core_t   core,
	output tpf_irq_t         irq,
	output logic             count_enable,
	output logic [2:0]       waveform_mode_field,
	output logic [7:0]       compare_a_value,
	output logic [7:0]       compare_b_value
);

	tpf_st_t st;
	tpf_st_t next_st;
	logic    pin_pulse;
	logic    ext_sel;
	logic    tap;
	logic    wr;
	logic    rd;
	logic    match_a;
	logic    match_b;
	logic    ovf_evt;

	// ------------------------------------------------------------------
	// External pin path, never routed through the prescaler.
	// ------------------------------------------------------------------
	tpf_pin_sync u_sync (
		.clk        (clk),
		.rst_b      (rst_b),
		.pin        (external_count_pin),
		.rising_sel (st.clk_sel[0]),
		.edge_pulse (pin_pulse)
	);

	assign ext_sel = (st.clk_sel == TPF_CS_EXTF) ||
	                 (st.clk_sel == TPF_CS_EXTR);

	// ------------------------------------------------------------------
	// Clock select decode.
	// ------------------------------------------------------------------
	always_comb begin
		unique case (tpf_cs_t'(st.clk_sel))
		TPF_CS_STOP:   tap = 1'b0;
		TPF_CS_SYS:    tap = 1'b1;
		TPF_CS_DIV8:   tap = ((st.presc & `TPF_TAP8) == `TPF_TAP8) &
		                     ~st.psr;
		TPF_CS_DIV64:  tap = ((st.presc & `TPF_TAP64) == `TPF_TAP64) &
		                     ~st.psr;
		TPF_CS_DIV256: tap = ((st.presc & `TPF_TAP256) == `TPF_TAP256) &
		                     ~st.psr;
		TPF_CS_DIV1K:  tap = (st.presc == `TPF_TAP1024) & ~st.psr;
		TPF_CS_EXTF,
		TPF_CS_EXTR:   tap = pin_pulse & ext_sel;
		endcase
	end

	// The tap fires as the low bits wrap, so registering it with the
	// counter keeps the first count within 1 to N cycles.
	assign count_enable = tap;

	// ------------------------------------------------------------------
	// Event detection from the counter core.
	// ------------------------------------------------------------------
	assign match_a = core.cnt_step && !core.wr_block &&
	                 (core.count == st.cmp_a);
	assign match_b = core.cnt_step && !core.wr_block &&
	                 (core.count == st.cmp_b);

	always_comb begin
		ovf_evt = 1'b0;
		if (core.cnt_step) begin
			unique case (st.wave_mode)
			3'h0, 3'h2, 3'h3: ovf_evt = (core.count == `TPF_MAX);
			3'h1, 3'h5:       ovf_evt = (core.count == `TPF_BOTTOM) &&
			                            core.down;
			3'h7:             ovf_evt = core.top_hit;
			default:          ovf_evt = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// APB slave, zero wait states.
	// ------------------------------------------------------------------
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	always_comb begin
		next_st         = st;
		next_st.presc   = st.presc + 10'h001;
		next_st.pready  = psel && !penable;
		next_st.pslverr = 1'b0;

		// Prescaler reset self clears unless synchronisation mode holds it.
		if (st.psr) begin
			next_st.presc = '0;
			if (!st.sync_mode) begin
				next_st.psr = 1'b0;
			end
		end

		// Acknowledge and write-one clear first, so new events win.
		if (vec_ack.ack_ovf) begin
			next_st.flags[0] = 1'b0;
		end
		if (vec_ack.ack_cmpa) begin
			next_st.flags[1] = 1'b0;
		end
		if (vec_ack.ack_cmpb) begin
			next_st.flags[2] = 1'b0;
		end

		if (wr) begin
			unique case (paddr)
			`TPF_OFS_FLAGS: begin
				next_st.flags = next_st.flags &
				                ~pwdata[`TPF_BIT_CMPB:`TPF_BIT_OVF];
			end
			`TPF_OFS_MASK: begin
				next_st.enables = pwdata[`TPF_BIT_CMPB:`TPF_BIT_OVF];
			end
			`TPF_OFS_GTC: begin
				next_st.sync_mode = pwdata[`TPF_BIT_SYNC];
				next_st.psr       = pwdata[`TPF_BIT_PSR] |
				                    (st.psr & pwdata[`TPF_BIT_SYNC]);
				if (!pwdata[`TPF_BIT_SYNC]) begin
					next_st.psr = pwdata[`TPF_BIT_PSR];
				end
			end
			`TPF_OFS_CTRL: begin
				next_st.clk_sel   = pwdata[2:0];
				next_st.wave_mode = pwdata[6:4];
			end
			`TPF_OFS_CMP: begin
				next_st.cmp_a = pwdata[7:0];
				next_st.cmp_b = pwdata[15:8];
			end
			default: next_st.pslverr = 1'b0;
			endcase
		end

		if (ovf_evt) begin
			next_st.flags[0] = 1'b1;
		end
		if (match_a) begin
			next_st.flags[1] = 1'b1;
		end
		if (match_b) begin
			next_st.flags[2] = 1'b1;
		end

		next_st.prdata = '0;
		if (rd) begin
			unique case (paddr)
			`TPF_OFS_FLAGS: next_st.prdata = {28'h0, st.flags, 1'b0};
			`TPF_OFS_MASK:  next_st.prdata = {28'h0, st.enables, 1'b0};
			`TPF_OFS_GTC:   next_st.prdata = {24'h0, st.sync_mode, 6'h00,
			                                  st.psr};
			`TPF_OFS_CTRL:  next_st.prdata = {25'h0, st.wave_mode, 1'b0,
			                                  st.clk_sel};
			`TPF_OFS_CMP:   next_st.prdata = {16'h0, st.cmp_b, st.cmp_a};
			default:        next_st.prdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st       <= '0;
			st.flags <= 3'(`TPF_RST_FLAGS >> `TPF_BIT_OVF);
		end else begin
			st <= next_st;
		end
	end

	assign pready  = st.pready | (psel & penable);
	assign prdata  = st.prdata;
	assign pslverr = st.pslverr;

	// Requests are qualified levels; the core acknowledges per source.
	assign irq.req_ovf  = st.flags[0] & st.enables[0] & global_irq_enable;
	assign irq.req_cmpa = st.flags[1] & st.enables[1] & global_irq_enable;
	assign irq.req_cmpb = st.flags[2] & st.enables[2] & global_irq_enable;

	assign waveform_mode_field = st.wave_mode;
	assign compare_a_value     = st.cmp_a;
	assign compare_b_value     = st.cmp_b;

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	sequence s_psr_written;
		wr && paddr == `TPF_OFS_GTC && pwdata[`TPF_BIT_PSR] &&
		!pwdata[`TPF_BIT_SYNC];
	endsequence

	a_cmpb_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		match_b |=> st.flags[2]) else $error("compare-B flag not set");
	a_cmpa_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		match_a |=> st.flags[1]) else $error("compare-A flag not set");
	a_ovf_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
		ovf_evt |=> st.flags[0]) else $error("overflow flag not set");
	a_ack_clears_flag: assert property (@(posedge clk) disable iff (!rst_b)
		vec_ack.ack_ovf && !ovf_evt |=> !st.flags[0])
		else $error("acknowledge did not clear overflow flag");
	a_irq_qualified: assert property (@(posedge clk) disable iff (!rst_b)
		irq.req_cmpa |-> global_irq_enable && st.enables[1] && st.flags[1])
		else $error("unqualified compare-A request");
	a_flags_reserved: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(st.pready) && $past(rd) && $past(paddr) == `TPF_OFS_FLAGS
		|-> prdata[31:4] == 28'h0 && prdata[0] == 1'b0)
		else $error("reserved flag bits read nonzero");
	a_sys_every_cycle: assert property (@(posedge clk) disable iff (!rst_b)
		st.clk_sel == 3'h1 |-> count_enable)
		else $error("system select missed a cycle");
	a_psr_self_clear: assert property (@(posedge clk) disable iff (!rst_b)
		s_psr_written |=> st.psr ##1 !st.psr && st.presc == 10'h000)
		else $error("prescaler reset did not self clear");
	a_tap_div8: assert property (@(posedge clk) disable iff (!rst_b)
		st.clk_sel == 3'h2 && count_enable |-> ##1
		(st.clk_sel != 3'h2 || !count_enable) [*7])
		else $error("divide-by-8 tap too frequent");

	// ------------------------------------------------------------------
	// Further checks on flag clearing and setting, masks, prescaler control, clock select and the pin path.
	// ------------------------------------------------------------------
	sequence s_ovf_wr_one;
		wr && paddr == `TPF_OFS_FLAGS && pwdata[`TPF_BIT_OVF];
	endsequence

	sequence s_sync_cleared;
		wr && paddr == `TPF_OFS_GTC && !pwdata[`TPF_BIT_SYNC] &&
		!pwdata[`TPF_BIT_PSR];
	endsequence

	sequence s_bottom_step;
		core.cnt_step && core.down && core.count == `TPF_BOTTOM &&
		(st.wave_mode == 3'h1 || st.wave_mode == 3'h5);
	endsequence

	a_wr_one_clears: assert property (@(posedge clk) disable iff (!rst_b)
		s_ovf_wr_one ##0 !ovf_evt |=> !st.flags[0])
		else $error("write one did not clear overflow flag");
	a_wr_zero_keeps: assert property (@(posedge clk) disable iff (!rst_b)
		wr && paddr == `TPF_OFS_FLAGS && !pwdata[`TPF_BIT_CMPA] &&
		st.flags[1] && !vec_ack.ack_cmpa |=> st.flags[1])
		else $error("write zero changed compare-A flag");
	a_mask_write: assert property (@(posedge clk) disable iff (!rst_b)
		wr && paddr == `TPF_OFS_MASK
		|=> st.enables[0] == $past(pwdata[`TPF_BIT_OVF]))
		else $error("overflow enable not written");
	a_ovf_req_qual: assert property (@(posedge clk) disable iff (!rst_b)
		irq.req_ovf == (st.flags[0] && st.enables[0] && global_irq_enable))
		else $error("overflow request not qualified");
	a_sync_holds: assert property (@(posedge clk) disable iff (!rst_b)
		st.sync_mode && st.psr && !wr |=> st.psr)
		else $error("sync mode lost prescaler reset");
	a_sync_off: assert property (@(posedge clk) disable iff (!rst_b)
		s_sync_cleared |=> !st.psr && !st.sync_mode)
		else $error("clearing sync mode left prescaler reset");
	// A held prescaler reset must stop the four divided taps, or configuration done
	// under sync mode could advance the counter.
	a_psr_halts: assert property (@(posedge clk) disable iff (!rst_b)
		st.psr && st.clk_sel >= 3'h2 && st.clk_sel <= 3'h5 |-> !count_enable)
		else $error("tap fired during prescaler reset");
	a_stop_no_count: assert property (@(posedge clk) disable iff (!rst_b)
		st.clk_sel == 3'h0 |-> !count_enable)
		else $error("count enable while stopped");
	a_ext_single: assert property (@(posedge clk) disable iff (!rst_b)
		ext_sel && count_enable |=> !count_enable)
		else $error("pin edge gave more than one pulse");
	a_ext_direct: assert property (@(posedge clk) disable iff (!rst_b)
		ext_sel |-> count_enable == pin_pulse)
		else $error("pin count not routed directly");
	a_bottom_ovf: assert property (@(posedge clk) disable iff (!rst_b)
		s_bottom_step |=> st.flags[0])
		else $error("phase-correct overflow missed at bottom");
	a_top_ovf: assert property (@(posedge clk) disable iff (!rst_b)
		core.cnt_step && core.top_hit && st.wave_mode == 3'h7
		|=> st.flags[0])
		else $error("fast mode overflow missed at top");
	a_tap_div64: assert property (@(posedge clk) disable iff (!rst_b)
		st.clk_sel == 3'h3 && count_enable |-> ##1
		(st.clk_sel != 3'h3 || !count_enable) [*8])
		else $error("divide-by-64 tap too frequent");
	// The prescaler is not restarted by a select change, so the first
	// count may come late, but never later than one full period.
	a_first_tap: assert property (@(posedge clk) disable iff (!rst_b)
		$changed(st.clk_sel) && st.clk_sel == 3'h2 && !st.psr &&
		!st.sync_mode |-> ##[0:8] count_enable)
		else $error("first divide-by-8 count too late");

endmodule // tpf_top

/* File: include/tpf_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts for the timer
 * prescaler and event flag block.
 * Assumes inclusion by bare name from the design modules and the bench.
 */
`ifndef TPF_CFG_SVH
`define TPF_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the APB.
// ----------------------------------------------------------------------
`define TPF_OFS_FLAGS     12'h000
`define TPF_OFS_MASK      12'h004
`define TPF_OFS_GTC       12'h008
`define TPF_OFS_CTRL      12'h00c
`define TPF_OFS_CMP       12'h010

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define TPF_BIT_CMPB      3
`define TPF_BIT_CMPA      2
`define TPF_BIT_OVF       1
`define TPF_BIT_SYNC      7
`define TPF_BIT_PSR       0

// ----------------------------------------------------------------------
// Reset values and constants.
// ----------------------------------------------------------------------
`define TPF_RST_FLAGS     8'h00
`define TPF_RST_GTC       8'h00
`define TPF_MAX           8'hff
`define TPF_BOTTOM        8'h00

// ----------------------------------------------------------------------
// Prescaler tap masks (divide by 8, 64, 256 and 1024).
// ----------------------------------------------------------------------
`define TPF_TAP8          10'h007
`define TPF_TAP64         10'h03f
`define TPF_TAP256        10'h0ff
`define TPF_TAP1024       10'h3ff

`endif

/* File: include/tpf_pkg.sv */
/*
 * Types shared by the timer prescaler and event flag block.
 * Assumes tpf_cfg.svh is on the include path.
 */
package tpf_pkg;

	// ------------------------------------------------------------------
	// Clock select codes.
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		TPF_CS_STOP   = 3'h0,
		TPF_CS_SYS    = 3'h1,
		TPF_CS_DIV8   = 3'h2,
		TPF_CS_DIV64  = 3'h3,
		TPF_CS_DIV256 = 3'h4,
		TPF_CS_DIV1K  = 3'h5,
		TPF_CS_EXTF   = 3'h6,
		TPF_CS_EXTR   = 3'h7
	} tpf_cs_t;

	// Strobes from and level requests to the processor core.
	typedef struct packed {
		logic ack_ovf;
		logic ack_cmpa;
		logic ack_cmpb;
	} tpf_ack_t;

	typedef struct packed {
		logic req_ovf;
		logic req_cmpa;
		logic req_cmpb;
	} tpf_irq_t;

	// Strobes from the counter core.
	typedef struct packed {
		logic [7:0] count;
		logic       cnt_step;
		logic       top_hit;
		logic       down;
		logic       wr_block;
	} tpf_core_t;

	typedef struct packed {
		logic       stop;
		logic       q1;
		logic       q2;
		logic       q3;
		logic       pin_lvl;
	} tpf_sync_st_t;

	typedef struct packed {
		logic [2:0] flags;
		logic [2:0] enables;
		logic       sync_mode;
		logic       psr;
		logic [2:0] clk_sel;
		logic [2:0] wave_mode;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic [9:0] presc;
		logic       pready;
		logic [31:0] prdata;
		logic       pslverr;
	} tpf_st_t;

endpackage

/* File: sim/timer0_prescaler_and_flags_tb.sv */
/*
 * Self-checking bench for the timer prescaler and event flag block.
 * Assumes tpf_cfg.svh on the include path and a zero-wait APB slave.
 */
`include "tpf_cfg.svh"

module timer0_prescaler_and_flags_tb
	import tpf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, gie;
	logic count_enable, ack_on, go, pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  wave;
	logic [7:0]  cmpa_o, cmpb_o, a, b;
	tpf_core_t   core;
	tpf_irq_t    irq;
	tpf_ack_t    vec_ack;
	int          err_total, checks_done;
	logic [31:0] exp_q[$];
	int          div[6] = '{0, 1, 8, 64, 256, 1024};
	int          md[6] = '{0, 1, 2, 3, 5, 7};

	tpf_top DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .external_count_pin(pin),
		.global_irq_enable(gie), .vec_ack(vec_ack), .core(core), .irq(irq),
		.count_enable(count_enable), .waveform_mode_field(wave),
		.compare_a_value(cmpa_o), .compare_b_value(cmpb_o));

	tpf_core_model PRT (.clk(clk), .rst_b(rst_b), .irq(irq), .ack_on(ack_on),
		.go(go), .vec_ack(vec_ack), .pin(pin));

	always #2 clk = ~clk;

	// ------------------------------------------------------------------
	// Bus cycles and comparisons.
	// ------------------------------------------------------------------
	task end_of_test;
		if (err_total == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			end_of_test;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask

	task rd(input logic [11:0] ad, input logic [31:0] exp);
		exp_q.push_back(exp);
		apb(1'b0, ad, 32'h0);
	endtask

	task ev(input logic [7:0] c, input logic st, tp, dn);
		@(posedge clk);
		core <= {c, st, tp, dn, 1'b0};
		@(posedge clk);
		core <= {8'h01, 4'h0};
	endtask

	task cnt(input int cyc, input logic [31:0] exp);
		int k;
		k = 0;
		repeat (cyc) begin
			@(posedge clk);
			if (count_enable === 1'b1) k++;
		end
		chk(32'(k), exp);
	endtask

	// Read data is taken at the edge that closes the access phase.
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) chk(prdata, 32'hdead);
			else chk(prdata, exp_q.pop_front());
		end
		if (psel && penable && pready === 1'b1) begin
			chk(32'(pslverr), 32'h0);
		end
	end

	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{psel, penable, pwrite, ack_on, go} = '0;
		paddr = '0;
		pwdata = '0;
		gie = 1'b1;
		core = {8'h01, 4'h0};
		err_total = 0;
		checks_done = 0;
		void'($urandom(32'haf71));
		a = 8'h10 + 8'($urandom % 128);
		b = a + 8'h20;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(`TPF_OFS_FLAGS, 32'h0);
		rd(`TPF_OFS_GTC, 32'h0);
		rd(12'h0f0, 32'h0);
		wr(`TPF_OFS_CMP, {16'h0, b, a});
		@(posedge clk);
		chk({16'h0, cmpb_o, cmpa_o}, {16'h0, b, a});
		wr(`TPF_OFS_MASK, 32'h0e);
		for (int i = 0; i < 3; i++) begin
			ev(i == 0 ? 8'hff : i == 1 ? a : b, 1'b1, 1'b0, 1'b0);
			rd(`TPF_OFS_FLAGS, 32'h02 << i);
			chk(32'(irq), 32'(3'b100 >> i));
			gie <= 1'b0;
			@(posedge clk);
			chk(32'(irq), 32'h0);
			gie <= 1'b1;
			wr(`TPF_OFS_FLAGS, 32'hf1);
			rd(`TPF_OFS_FLAGS, 32'h02 << i);
			wr(`TPF_OFS_FLAGS, 32'h02 << i);
			rd(`TPF_OFS_FLAGS, 32'h0);
		end
		ack_on <= 1'b1;
		ev(a, 1'b1, 1'b0, 1'b0);
		repeat (4) @(posedge clk);
		rd(`TPF_OFS_FLAGS, 32'h0);
		ack_on <= 1'b0;
		foreach (md[j]) begin
			wr(`TPF_OFS_CTRL, 32'(md[j]) << 4);
			@(posedge clk);
			chk(32'(wave), 32'(md[j]));
			if (md[j] == 1 || md[j] == 5) ev(8'h00, 1'b1, 1'b0, 1'b1);
			else if (md[j] == 7) ev(8'h05, 1'b1, 1'b1, 1'b0);
			else ev(8'hff, 1'b1, 1'b0, 1'b0);
			rd(`TPF_OFS_FLAGS, 32'h02);
			wr(`TPF_OFS_FLAGS, 32'h02);
		end
		for (int cs = 0; cs < 6; cs++) begin
			wr(`TPF_OFS_CTRL, 32'(cs));
			cnt(2048, cs == 0 ? 0 : 2048 / div[cs]);
		end
		wr(`TPF_OFS_GTC, 32'h81);
		rd(`TPF_OFS_GTC, 32'h81);
		wr(`TPF_OFS_CTRL, 32'h2);
		cnt(64, 0);
		wr(`TPF_OFS_GTC, 32'h0);
		rd(`TPF_OFS_GTC, 32'h0);
		cnt(64, 8);
		wr(`TPF_OFS_GTC, 32'h1);
		rd(`TPF_OFS_GTC, 32'h0);
		for (int cs = 7; cs > 5; cs--) begin
			wr(`TPF_OFS_CTRL, 32'(cs));
			@(posedge clk);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			cnt(40, 5);
		end
		end_of_test;
	end
endmodule // timer0_prescaler_and_flags_tb

/* File: sim/tpf_core_model.sv */
/*
 * Model of the processor core's vector acknowledge and the external count pin.
 * Assumes the bench raises go for one cycle to start a burst of pin edges.
 */
module tpf_core_model
	import tpf_pkg::*;
#(
	parameter int EDGES = 5
)
(
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire tpf_irq_t irq,
	input  wire logic     ack_on,
	input  wire logic     go,
	output tpf_ack_t      vec_ack,
	output logic          pin
);
	logic [5:0] left;
	logic [1:0] ph;

	// The strobe lasts one cycle so a cleared flag is never acked twice.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vec_ack <= '0;
		end else begin
			vec_ack <= ack_on ? tpf_ack_t'(irq & ~vec_ack) : '0;
		end
	end

	// Each level is held three cycles, and the pin rests low between bursts.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			left <= '0;
			ph   <= '0;
			pin  <= 1'b0;
		end else if (go) begin
			left <= 6'(2 * EDGES);
			ph   <= '0;
		end else if (left != 6'h00) begin
			ph <= ph + 2'h1;
			if (ph == 2'h2) begin
				ph   <= '0;
				pin  <= ~pin;
				left <= left - 6'h01;
			end
		end
	end
endmodule // tpf_core_model
